// ### core/vadc_pkg.sv
/*
  Constants for the voltage converter sequencer: register offsets, reset values,
  field positions, channel codes, timing counts and the sequencer state type.
  Assumes a 40 MHz system clock.
*/
package vadc_pkg;

  // Register offsets.
  localparam logic [7:0] ADDR_PROC_READING = 8'h21;
  localparam logic [7:0] ADDR_SUPPLY_READING = 8'h22;
  localparam logic [7:0] ADDR_CONFIG_ONE = 8'h40;
  localparam logic [7:0] ADDR_PROC_LOW = 8'h46;
  localparam logic [7:0] ADDR_PROC_HIGH = 8'h47;
  localparam logic [7:0] ADDR_SUPPLY_LOW = 8'h48;
  localparam logic [7:0] ADDR_SUPPLY_HIGH = 8'h49;
  localparam logic [7:0] ADDR_CHAN_SELECT = 8'h55;
  localparam logic [7:0] ADDR_CONFIG_TWO = 8'h73;

  // Reset values.
  localparam logic [7:0] RST_READING = 8'h00;
  localparam logic [7:0] RST_LOW_LIMIT = 8'h00;
  localparam logic [7:0] RST_HIGH_LIMIT = 8'hFF;
  localparam logic [7:0] RST_CONFIG = 8'h00;
  localparam logic [7:0] RST_CHAN_SELECT = 8'h00;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  // Field positions.
  localparam int CFG1_SUPPLY_5V_BIT = 7;
  localparam int CFG1_TIMEOUT_DIS_BIT = 6;
  localparam int CFG2_AVG_OFF_BIT = 4;
  localparam int CFG2_ATTEN_BYPASS_BIT = 5;
  localparam int CFG2_SINGLE_BIT = 6;
  localparam int CHAN_SEL_HI = 7;
  localparam int CHAN_SEL_LO = 5;

  // Converter geometry.
  localparam int ADC_BITS = 10;
  localparam int AVG_COUNT = 16;

  // Channel codes.
  localparam logic [2:0] CH_PROC = 3'h1;
  localparam logic [2:0] CH_SUPPLY = 3'h2;
  localparam logic [2:0] CH_REMOTE_ONE = 3'h5;
  localparam logic [2:0] CH_LOCAL_TEMP = 3'h6;
  localparam logic [2:0] CH_REMOTE_TWO = 3'h7;

  // Timing.
  localparam int CLK_PERIOD_PS = 25000;
  localparam int CONV_TIME_PS = 700000000;
  localparam int CONV_CYCLES_DEF = (CONV_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_START = 2'b01,
    SEQ_CONV = 2'b10
  } vadc_state_type;

endpackage

// ### core/vadc_sample_avg.sv
/*
  Sample averager: sums a fixed power-of-two count of converter samples and
  emits their mean, or passes each sample straight through when bypassed.
  Assumes samples arrive as one-cycle strobes on the same clock.
*/
module vadc_sample_avg #(
  parameter int DATA_W = 10,
  parameter int COUNT = 16
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Control.
  input wire logic clear,
  input wire logic bypass,
  // Samples in.
  input wire logic sampleValid,
  input wire logic [DATA_W-1:0] sampleData,
  // Result out.
  output logic resultValid,
  output logic [DATA_W-1:0] resultData
);

  localparam int CNT_W = $clog2(COUNT);
  localparam int SUM_W = DATA_W + CNT_W;
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(COUNT - 1);

  if (COUNT < 2 || (COUNT & (COUNT - 1)) != 0) begin : g_bad_count
    $error("vadc_sample_avg: COUNT must be a power of two of at least 2");
  end

  logic [SUM_W-1:0] sum_reg, sum_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic valid_reg, valid_next;
  logic [DATA_W-1:0] data_reg, data_next;
  logic [SUM_W-1:0] sumAdd;

  always_comb begin
    sumAdd = sum_reg + SUM_W'(sampleData);
    sum_next = sum_reg;
    cnt_next = cnt_reg;
    valid_next = 1'b0;
    data_next = data_reg;
    if (clear) begin
      sum_next = '0;
      cnt_next = '0;
    end else if (sampleValid) begin
      if (bypass) begin
        // One conversion per result when averaging is off.
        valid_next = 1'b1;
        data_next = sampleData;
        sum_next = '0;
        cnt_next = '0;
      end else if (cnt_reg == CNT_LAST) begin
        // The mean of full-range codes can never pass the top code.
        valid_next = 1'b1;
        data_next = sumAdd[SUM_W-1:CNT_W];
        sum_next = '0;
        cnt_next = '0;
      end else begin
        sum_next = sumAdd;
        cnt_next = cnt_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sum_reg <= '0;
      cnt_reg <= '0;
      valid_reg <= 1'b0;
      data_reg <= '0;
    end else begin
      sum_reg <= sum_next;
      cnt_reg <= cnt_next;
      valid_reg <= valid_next;
      data_reg <= data_next;
    end
  end

  assign resultValid = valid_reg;
  assign resultData = data_reg;

endmodule // vadc_sample_avg

// ### core/vadc_sequencer.sv
/*
  Voltage converter sequencer: paces the shared converter, averages results,
  holds readings and limits, compares against limits and raises alert requests.
  Assumes the converter macro and the bus engine run on clk; the bus engine
  keeps the register pointer and presents one access per cycle.
*/
// Notes on behaviour
// - All inputs share one 10-bit converter with a 0 to 2.25 V basic span.
// - Nominal rail voltage gives code 768, leaving headroom above it.
// - Codes saturate at 1023 and 0; quarter and half scale are 256 and 512.
// - Processor and supply reading registers reset to zero.
// - A reading above its high or below its low limit sets its status bit.
// - A limit violation on either channel can raise the alert request.
// - Low limits reset to 0x00 and high limits to 0xFF.
// - One conversion takes 0.7 ms; sixteen averaged give about 11 ms.
// - Sixteen readings are averaged before a value register is written.
// - Bit 4 of config two turns averaging off, one conversion per result.
// - Bit 5 of config two bypasses the processor rail attenuator.
// - Bit 6 of config two converts one selected channel repeatedly.
// - In single-channel mode the selected input converts every 0.7 ms.
// - Bits 7 to 5 of register 0x55 pick the single-channel input.
// - Bit 7 of config one rescales the supply channel for 5 V.
module vadc_sequencer
  import vadc_pkg::*;
#(
  parameter int CONV_CYCLES = CONV_CYCLES_DEF
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Register access from the bus engine.
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrEn,
  output logic [7:0] regRdData,
  // Converter macro.
  output logic adcStart,
  output logic [2:0] adcChannel,
  output logic adcAttenBypass,
  output logic adcSupplyScale,
  input wire logic adcDone,
  input wire logic [ADC_BITS-1:0] adcResult,
  // Status.
  output logic procLimitStatus,
  output logic supplyLimitStatus,
  output logic alertRequest,
  output logic busTimeoutDisable
);

  localparam int TMR_W = $clog2(CONV_CYCLES + 1);
  localparam logic [TMR_W-1:0] TMR_LOAD = TMR_W'(CONV_CYCLES - 2);

  if (CONV_CYCLES < 4) begin : g_bad_conv
    $error("vadc_sequencer: CONV_CYCLES must be at least 4");
  end

  // Register file.
  logic [7:0] procReading_reg, procReading_next;
  logic [7:0] supplyReading_reg, supplyReading_next;
  logic [7:0] cfgOne_reg, cfgOne_next;
  logic [7:0] cfgTwo_reg, cfgTwo_next;
  logic [7:0] chanSel_reg, chanSel_next;
  logic [7:0] procLow_reg, procLow_next;
  logic [7:0] procHigh_reg, procHigh_next;
  logic [7:0] supplyLow_reg, supplyLow_next;
  logic [7:0] supplyHigh_reg, supplyHigh_next;
  logic [7:0] rdData_reg, rdData_next;
  logic procStat_reg, procStat_next;
  logic supplyStat_reg, supplyStat_next;
  logic alert_reg, alert_next;

  // Sequencer.
  vadc_state_type state_reg, state_next;
  logic [TMR_W-1:0] timer_reg, timer_next;
  logic start_reg, start_next;
  logic doneSeen_reg, doneSeen_next;
  logic [2:0] measChan_reg, measChan_next;
  logic [2:0] rrChan_reg, rrChan_next;

  logic singleMode;
  logic [2:0] wantChan;
  logic sampleValid;
  logic avgClear;
  logic avgValid;
  logic [ADC_BITS-1:0] avgData;
  logic [7:0] resultByte;

  assign singleMode = cfgTwo_reg[CFG2_SINGLE_BIT];
  assign wantChan = singleMode ? chanSel_reg[CHAN_SEL_HI:CHAN_SEL_LO] : rrChan_reg;
  assign resultByte = avgData[ADC_BITS-1:ADC_BITS-8];

  // Conversion pacing.
  always_comb begin
    state_next = state_reg;
    timer_next = timer_reg;
    start_next = 1'b0;
    doneSeen_next = doneSeen_reg | adcDone;
    measChan_next = measChan_reg;
    sampleValid = 1'b0;
    avgClear = 1'b0;
    unique case (state_reg)
      SEQ_IDLE: begin
        state_next = SEQ_START;
      end
      SEQ_START: begin
        // A channel switch discards any partly built average.
        avgClear = (wantChan != measChan_reg);
        measChan_next = wantChan;
        start_next = 1'b1;
        doneSeen_next = 1'b0;
        timer_next = TMR_LOAD;
        state_next = SEQ_CONV;
      end
      SEQ_CONV: begin
        if (timer_reg != '0) begin
          timer_next = timer_reg - 1'b1;
        end else if (doneSeen_reg || adcDone) begin
          // Temperature codes convert but are stored elsewhere.
          sampleValid = (measChan_reg == CH_PROC) || (measChan_reg == CH_SUPPLY);
          state_next = SEQ_START;
        end
      end
      default: begin
        state_next = SEQ_IDLE;
      end
    endcase
  end

  vadc_sample_avg #(
    .DATA_W(ADC_BITS),
    .COUNT(AVG_COUNT)
  ) u_avg (
    .clk(clk),
    .rstn(rstn),
    .clear(avgClear),
    .bypass(cfgTwo_reg[CFG2_AVG_OFF_BIT]),
    .sampleValid(sampleValid),
    .sampleData(adcResult),
    .resultValid(avgValid),
    .resultData(avgData)
  );

  // Registers, limit checks and readback.
  always_comb begin
    procReading_next = procReading_reg;
    supplyReading_next = supplyReading_reg;
    cfgOne_next = cfgOne_reg;
    cfgTwo_next = cfgTwo_reg;
    chanSel_next = chanSel_reg;
    procLow_next = procLow_reg;
    procHigh_next = procHigh_reg;
    supplyLow_next = supplyLow_reg;
    supplyHigh_next = supplyHigh_reg;
    procStat_next = procStat_reg;
    supplyStat_next = supplyStat_reg;
    rrChan_next = rrChan_reg;
    if (regWrEn) begin
      unique case (regAddr)
        ADDR_CONFIG_ONE: cfgOne_next = regWrData;
        ADDR_CONFIG_TWO: cfgTwo_next = regWrData;
        ADDR_CHAN_SELECT: chanSel_next = regWrData;
        ADDR_PROC_LOW: procLow_next = regWrData;
        ADDR_PROC_HIGH: procHigh_next = regWrData;
        ADDR_SUPPLY_LOW: supplyLow_next = regWrData;
        ADDR_SUPPLY_HIGH: supplyHigh_next = regWrData;
        default: begin
        end
      endcase
    end
    if (avgValid) begin
      if (measChan_reg == CH_PROC) begin
        procReading_next = resultByte;
        procStat_next = (resultByte > procHigh_reg) || (resultByte < procLow_reg);
      end else begin
        supplyReading_next = resultByte;
        supplyStat_next = (resultByte > supplyHigh_reg) || (resultByte < supplyLow_reg);
      end
      rrChan_next = (rrChan_reg == CH_PROC) ? CH_SUPPLY : CH_PROC;
    end
    // Alert follows the status, so it drops once the condition is gone.
    alert_next = procStat_next | supplyStat_next;
    unique case (regAddr)
      ADDR_PROC_READING: rdData_next = procReading_reg;
      ADDR_SUPPLY_READING: rdData_next = supplyReading_reg;
      ADDR_CONFIG_ONE: rdData_next = cfgOne_reg;
      ADDR_CONFIG_TWO: rdData_next = cfgTwo_reg;
      ADDR_CHAN_SELECT: rdData_next = chanSel_reg;
      ADDR_PROC_LOW: rdData_next = procLow_reg;
      ADDR_PROC_HIGH: rdData_next = procHigh_reg;
      ADDR_SUPPLY_LOW: rdData_next = supplyLow_reg;
      ADDR_SUPPLY_HIGH: rdData_next = supplyHigh_reg;
      default: rdData_next = READ_UNMAPPED;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      procReading_reg <= RST_READING;
      supplyReading_reg <= RST_READING;
      cfgOne_reg <= RST_CONFIG;
      cfgTwo_reg <= RST_CONFIG;
      chanSel_reg <= RST_CHAN_SELECT;
      procLow_reg <= RST_LOW_LIMIT;
      procHigh_reg <= RST_HIGH_LIMIT;
      supplyLow_reg <= RST_LOW_LIMIT;
      supplyHigh_reg <= RST_HIGH_LIMIT;
      rdData_reg <= READ_UNMAPPED;
      procStat_reg <= 1'b0;
      supplyStat_reg <= 1'b0;
      alert_reg <= 1'b0;
      state_reg <= SEQ_IDLE;
      timer_reg <= '0;
      start_reg <= 1'b0;
      doneSeen_reg <= 1'b0;
      measChan_reg <= CH_PROC;
      rrChan_reg <= CH_PROC;
    end else begin
      procReading_reg <= procReading_next;
      supplyReading_reg <= supplyReading_next;
      cfgOne_reg <= cfgOne_next;
      cfgTwo_reg <= cfgTwo_next;
      chanSel_reg <= chanSel_next;
      procLow_reg <= procLow_next;
      procHigh_reg <= procHigh_next;
      supplyLow_reg <= supplyLow_next;
      supplyHigh_reg <= supplyHigh_next;
      rdData_reg <= rdData_next;
      procStat_reg <= procStat_next;
      supplyStat_reg <= supplyStat_next;
      alert_reg <= alert_next;
      state_reg <= state_next;
      timer_reg <= timer_next;
      start_reg <= start_next;
      doneSeen_reg <= doneSeen_next;
      measChan_reg <= measChan_next;
      rrChan_reg <= rrChan_next;
    end
  end

  assign regRdData = rdData_reg;
  assign adcStart = start_reg;
  assign adcChannel = measChan_reg;
  // Scaling for 768 at nominal rail lives in the analog front end.
  assign adcAttenBypass = cfgTwo_reg[CFG2_ATTEN_BYPASS_BIT];
  assign adcSupplyScale = cfgOne_reg[CFG1_SUPPLY_5V_BIT];
  assign busTimeoutDisable = cfgOne_reg[CFG1_TIMEOUT_DIS_BIT];
  assign procLimitStatus = procStat_reg;
  assign supplyLimitStatus = supplyStat_reg;
  assign alertRequest = alert_reg;

  // Checking helpers: cycles since the last start.
  logic [31:0] gapCount_reg;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      gapCount_reg <= 32'hFFFF_FFFF;
    end else if (start_reg) begin
      gapCount_reg <= 32'h0000_0001;
    end else if (gapCount_reg != 32'hFFFF_FFFF) begin
      gapCount_reg <= gapCount_reg + 32'h0000_0001;
    end
  end

  start_pulse_a: assert property (@(posedge clk) disable iff (!rstn)
    adcStart |=> !adcStart)
    else $error("converter start lasted more than one cycle");

  conv_spacing_a: assert property (@(posedge clk) disable iff (!rstn)
    adcStart |-> gapCount_reg >= 32'(CONV_CYCLES))
    else $error("converter started sooner than one conversion time");

  single_chan_a: assert property (@(posedge clk) disable iff (!rstn)
    (state_reg == SEQ_START && singleMode) |=> adcChannel == $past(chanSel_reg[7:5]))
    else $error("single mode converted a channel other than the selected one");

  bypass_fast_a: assert property (@(posedge clk) disable iff (!rstn)
    (sampleValid && !avgClear && cfgTwo_reg[CFG2_AVG_OFF_BIT]) |=> avgValid)
    else $error("averaging off did not give a result per conversion");

  proc_store_a: assert property (@(posedge clk) disable iff (!rstn)
    (avgValid && measChan_reg == CH_PROC) |=> procReading_reg == $past(avgData[9:2]))
    else $error("processor reading did not take the result's upper byte");

  supply_store_a: assert property (@(posedge clk) disable iff (!rstn)
    (avgValid && measChan_reg == CH_SUPPLY) |=> supplyReading_reg == $past(avgData[9:2]))
    else $error("supply reading did not take the result's upper byte");

  proc_status_a: assert property (@(posedge clk) disable iff (!rstn)
    (avgValid && measChan_reg == CH_PROC) |=>
      procLimitStatus == (($past(resultByte) > $past(procHigh_reg)) ||
                          ($past(resultByte) < $past(procLow_reg))))
    else $error("processor status does not match the limit comparison");

  status_update_a: assert property (@(posedge clk) disable iff (!rstn)
    (avgValid && measChan_reg == CH_SUPPLY) |=>
      supplyLimitStatus == (($past(resultByte) > $past(supplyHigh_reg)) ||
                            ($past(resultByte) < $past(supplyLow_reg))))
    else $error("supply status does not match the limit comparison");

  alert_level_a: assert property (@(posedge clk) disable iff (!rstn)
    alertRequest == (procLimitStatus || supplyLimitStatus))
    else $error("alert request disagrees with limit status");

  read_back_a: assert property (@(posedge clk) disable iff (!rstn)
    (regAddr == ADDR_PROC_READING) |=> regRdData == $past(procReading_reg))
    else $error("processor reading readback wrong");

endmodule // vadc_sequencer

// ### testbench/tb_top.sv
/*
  Self-checking bench for the voltage converter sequencer with a converter model.
  Assumes a 40 MHz clock and a shortened conversion count of eight cycles.
*/
module tb_top
  import vadc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int N = 8;
  logic clk, rstn, regWrEn, adcStart, adcAttenBypass, adcSupplyScale, adcDone;
  logic procLimitStatus, supplyLimitStatus, alertRequest, busTimeoutDisable, slow;
  logic [7:0] regAddr, regWrData, regRdData, rv;
  logic [2:0] adcChannel;
  logic [ADC_BITS-1:0] adcResult, procCode, supplyCode, altDelta;
  int failures = 0;
  int checked = 0;
  int n;

  vadc_sequencer #(.CONV_CYCLES(N)) i_dut (.clk(clk), .rstn(rstn), .regAddr(regAddr),
    .regWrData(regWrData), .regWrEn(regWrEn), .regRdData(regRdData), .adcStart(adcStart),
    .adcChannel(adcChannel), .adcAttenBypass(adcAttenBypass), .adcSupplyScale(adcSupplyScale),
    .adcDone(adcDone), .adcResult(adcResult), .procLimitStatus(procLimitStatus),
    .supplyLimitStatus(supplyLimitStatus), .alertRequest(alertRequest),
    .busTimeoutDisable(busTimeoutDisable));
  vadc_conv_model i_conv (.clk(clk), .rstn(rstn), .adcStart(adcStart), .adcChannel(adcChannel),
    .adcDone(adcDone), .adcResult(adcResult), .slow(slow), .procCode(procCode),
    .supplyCode(supplyCode), .altDelta(altDelta));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic close_out();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chkv(input string name, input logic [9:0] exp, input logic [9:0] got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic chkn(input string name, input int lo, input int hi, input int got);
    checked++;
    if (got < lo || got > hi) begin
      failures++;
      $display("[ERR] %s expected %0d to %0d seen %0d", name, lo, hi, got);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  // Writes leave one idle cycle so the strobe is never lowered and raised at once.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    tick(1);
    regWrEn = 1'b0;
    tick(1);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    regAddr = a;
    tick(1);
    d = regRdData;
  endtask
  task automatic chkr(input string name, input logic [7:0] a, input logic [7:0] e);
    rd(a, rv);
    chkv(name, {2'b00, e}, {2'b00, rv});
  endtask
  task automatic wait_rd(input string name, input logic [7:0] a, input logic [7:0] e);
    int i;
    for (i = 0; i < 200; i++) begin
      rd(a, rv);
      if (rv === e) break;
    end
    chkv(name, {2'b00, e}, {2'b00, rv});
    if (i == 200) close_out();
  endtask
  task automatic start_gap(output int g);
    int i;
    for (i = 0; i < 100 && adcStart !== 1'b1; i++) tick(1);
    g = 0;
    do begin
      tick(1);
      g++;
    end while (adcStart !== 1'b1 && g < 100);
    if (g == 100) begin
      chkn("startGap", 1, 99, g);
      close_out();
    end
  endtask

  task automatic t_reset();
    logic [7:0] addrs [7] = '{8'h21, 8'h22, 8'h46, 8'h47, 8'h48, 8'h49, 8'h30};
    logic [7:0] exps [7] = '{8'h00, 8'h00, 8'h00, 8'hFF, 8'h00, 8'hFF, 8'h00};
    for (int i = 0; i < 7; i++) chkr("resetValue", addrs[i], exps[i]);
    chkv("alert", 10'h000, {9'h000, alertRequest});
    wr(8'h21, 8'h5A);
    chkr("readOnly", 8'h21, 8'h00);
  endtask
  task automatic t_config();
    for (int v = 1; v >= 0; v--) begin
      wr(8'h40, v[0] ? 8'hC0 : 8'h00);
      wr(8'h73, v[0] ? 8'h20 : 8'h00);
      chkr("config", 8'h40, v[0] ? 8'hC0 : 8'h00);
      tick(3 * N);
      chkv("scale", {9'h000, v[0]}, {9'h000, adcSupplyScale});
      chkv("bypass", {9'h000, v[0]}, {9'h000, adcAttenBypass});
      chkv("timeoutDis", {9'h000, v[0]}, {9'h000, busTimeoutDisable});
    end
  endtask
  task automatic t_single_limits();
    procCode = 10'h300;
    wr(8'h55, 8'h20);
    wr(8'h73, 8'h50);
    wait_rd("procReading", 8'h21, 8'hC0);
    chkv("channel", {7'h00, CH_PROC}, {7'h00, adcChannel});
    start_gap(n);
    start_gap(n);
    chkn("convGap", N, N, n);
    slow = 1'b1;
    start_gap(n);
    start_gap(n);
    chkn("slowGap", 20, 23, n);
    slow = 1'b0;
    wr(8'h47, 8'h80);
    tick(3 * N);
    chkv("procHigh", 10'h001, {9'h000, procLimitStatus});
    chkv("alertHigh", 10'h001, {9'h000, alertRequest});
    wr(8'h47, 8'hFF);
    wr(8'h46, 8'hC1);
    tick(3 * N);
    chkv("procLow", 10'h001, {9'h000, procLimitStatus});
    wr(8'h46, 8'hC0);
    tick(3 * N);
    chkv("procInside", 10'h000, {9'h000, procLimitStatus});
    chkv("alertClear", 10'h000, {9'h000, alertRequest});
  endtask
  task automatic t_supply();
    supplyCode = 10'h3FF;
    wr(8'h55, 8'h40);
    wait_rd("supplyReading", 8'h22, 8'hFF);
    chkv("channel", {7'h00, CH_SUPPLY}, {7'h00, adcChannel});
    wr(8'h49, 8'hFE);
    tick(3 * N);
    chkv("supplyHigh", 10'h001, {9'h000, supplyLimitStatus});
    chkv("alertSupply", 10'h001, {9'h000, alertRequest});
    wr(8'h49, 8'hFF);
    tick(3 * N);
    chkv("supplyInside", 10'h000, {9'h000, supplyLimitStatus});
  endtask
  task automatic t_temp_codes();
    logic [2:0] codes [3] = '{CH_REMOTE_ONE, CH_LOCAL_TEMP, CH_REMOTE_TWO};
    for (int i = 0; i < 3; i++) begin
      wr(8'h55, {codes[i], 5'h00});
      tick(3 * N);
      chkv("tempChannel", {7'h00, codes[i]}, {7'h00, adcChannel});
    end
    chkr("supplyKept", 8'h22, 8'hFF);
  endtask
  task automatic t_average();
    int i;
    procCode = 10'h100;
    altDelta = 10'h010;
    wr(8'h73, 8'h40);
    wr(8'h55, 8'h20);
    regAddr = 8'h21;
    n = 0;
    for (i = 0; i < 600; i++) begin
      tick(1);
      if (adcStart === 1'b1) n++;
      if (regRdData !== 8'hC0) break;
    end
    chkv("avgReading", 10'h042, {2'b00, regRdData});
    chkn("avgStarts", 16, 18, n);
    if (i == 600) close_out();
  endtask
  task automatic t_cycling();
    procCode = 10'h200;
    supplyCode = 10'h100;
    altDelta = 10'h000;
    wr(8'h73, 8'h10);
    wait_rd("cycleProc", 8'h21, 8'h80);
    wait_rd("cycleSupply", 8'h22, 8'h40);
  endtask

  initial begin
    rstn = 1'b0;
    regAddr = 8'h00;
    regWrData = 8'h00;
    regWrEn = 1'b0;
    slow = 1'b0;
    procCode = '0;
    supplyCode = '0;
    altDelta = '0;
    repeat (6) @(posedge clk);
    #1;
    rstn = 1'b1;
    t_reset();
    t_config();
    t_single_limits();
    t_supply();
    t_temp_codes();
    t_average();
    t_cycling();
    close_out();
  end
endmodule // tb_top

// ### testbench/vadc_conv_model.sv
/*
  Converter macro model: answers each start pulse with a done pulse and a code
  for the selected channel, promptly or slowly. Assumes starts are one-cycle
  pulses on clk and that the bench sets the analog codes.
*/
module vadc_conv_model
  import vadc_pkg::*;
#(
  parameter int FAST_DELAY = 2,
  parameter int SLOW_DELAY = 20
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Converter handshake.
  input wire logic adcStart,
  input wire logic [2:0] adcChannel,
  output logic adcDone,
  output logic [ADC_BITS-1:0] adcResult,
  // Converter speed and analog levels set by the bench.
  input wire logic slow,
  input wire logic [ADC_BITS-1:0] procCode,
  input wire logic [ADC_BITS-1:0] supplyCode,
  input wire logic [ADC_BITS-1:0] altDelta
);
  timeunit 1ns;
  timeprecision 100ps;
  int waitCount;
  logic toggle;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      waitCount <= 0;
      toggle <= 1'b0;
      adcDone <= 1'b0;
      adcResult <= '0;
    end else if (adcStart) begin
      waitCount <= slow ? SLOW_DELAY : FAST_DELAY;
      adcDone <= 1'b0;
    end else if (waitCount == 1) begin
      waitCount <= 0;
      adcDone <= 1'b1;
      toggle <= ~toggle;
      // Alternate codes let the bench tell a true mean from a single sample.
      case (adcChannel)
        CH_PROC: adcResult <= procCode + (toggle ? altDelta : '0);
        CH_SUPPLY: adcResult <= supplyCode + (toggle ? altDelta : '0);
        default: adcResult <= 10'h155;
      endcase
    end else begin
      adcDone <= 1'b0;
      if (waitCount > 1) begin
        waitCount <= waitCount - 1;
        // The code is not valid mid-conversion, so it keeps changing.
        adcResult <= ~adcResult;
      end
    end
  end
endmodule // vadc_conv_model
